/* File: verilog/srw_supervisor.sv */
// supply reset generator with independent watchdog
module srw_supervisor #(
	parameter int unsigned TICK_DIV = srw_pkg::TICK_DIV,
	parameter int unsigned RESET_TICKS = srw_pkg::RESET_TICKS,
	parameter int unsigned WDOG_TICKS = srw_pkg::WDOG_TICKS
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic supply_good_i,
	input wire logic manual_reset_n_i,
	input wire logic watchdog_kick_in_i,
	input wire logic watchdog_kick_undriven_i,
	output logic reset_o,
	output logic reset_n_o,
	output logic watchdog_expired_n_o,
	output logic watchdog_expired_n_oe_n_o
);
	// ------------------------------------------------------------
	// time base
	// ------------------------------------------------------------
	srw_tick_if tick_bus ();
	srw_tick_gen #(
		.DIV(TICK_DIV)
	) u_tick (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.tick_o(tick_bus)
	);
	wire logic tick = tick_bus.tick;
	// ------------------------------------------------------------
	// reset pulse state machine
	// ------------------------------------------------------------
	srw_pkg::srw_state_type state;
	srw_pkg::srw_state_type next_state;
	logic [srw_pkg::CNT_W-1:0] rst_cnt;
	logic [srw_pkg::CNT_W-1:0] next_rst_cnt;
	logic rst_active;
	logic next_rst_active;
	logic hold_cond;
	// supply and manual reset are sampled as synchronous levels
	assign hold_cond = !supply_good_i || !manual_reset_n_i;
	always_comb begin
		next_state = state;
		next_rst_cnt = rst_cnt;
		next_rst_active = rst_active;
		case (state)
			srw_pkg::SRW_HOLD: begin
				next_rst_active = 1'b1;
				next_rst_cnt = '0;
				if (!hold_cond)
					next_state = srw_pkg::SRW_STRETCH;
			end
			srw_pkg::SRW_STRETCH: begin
				next_rst_active = 1'b1;
				if (hold_cond) begin
					next_state = srw_pkg::SRW_HOLD;
					next_rst_cnt = '0;
				end else if (tick) begin
					if (rst_cnt == srw_pkg::CNT_W'(RESET_TICKS - 1)) begin
						next_state = srw_pkg::SRW_RUN;
						next_rst_active = 1'b0;
					end else
						next_rst_cnt = rst_cnt + 16'h0001;
				end
			end
			srw_pkg::SRW_RUN: begin
				if (hold_cond) begin
					next_state = srw_pkg::SRW_HOLD;
					next_rst_active = 1'b1;
				end
			end
			default: begin
				next_state = srw_pkg::SRW_HOLD;
				next_rst_active = 1'b1;
				next_rst_cnt = '0;
			end
		endcase
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= srw_pkg::SRW_HOLD;
			rst_cnt <= '0;
			rst_active <= srw_pkg::RESET_ACTIVE_RST;
		end else begin
			state <= next_state;
			rst_cnt <= next_rst_cnt;
			rst_active <= next_rst_active;
		end
	end
	// supply loss shows at once, without waiting for a clock edge
	assign reset_o = rst_active || !supply_good_i;
	assign reset_n_o = !reset_o;
	// ------------------------------------------------------------
	// watchdog
	// ------------------------------------------------------------
	logic kick_prev;
	logic next_kick_prev;
	logic [srw_pkg::CNT_W-1:0] wd_cnt;
	logic [srw_pkg::CNT_W-1:0] next_wd_cnt;
	logic wd_expired;
	logic next_wd_expired;
	logic wd_clear;
	assign wd_clear = reset_o || watchdog_kick_undriven_i
		|| (watchdog_kick_in_i != kick_prev);
	always_comb begin
		next_kick_prev = watchdog_kick_in_i;
		next_wd_cnt = wd_cnt;
		next_wd_expired = wd_expired;
		if (wd_clear) begin
			next_wd_cnt = '0;
			next_wd_expired = 1'b0;
		end else if (tick && !wd_expired) begin
			if (wd_cnt == srw_pkg::CNT_W'(WDOG_TICKS - 1))
				next_wd_expired = 1'b1;
			else
				next_wd_cnt = wd_cnt + 16'h0001;
		end
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			kick_prev <= 1'b0;
			wd_cnt <= '0;
			wd_expired <= srw_pkg::WDOG_EXPIRED_RST;
		end else begin
			kick_prev <= next_kick_prev;
			wd_cnt <= next_wd_cnt;
			wd_expired <= next_wd_expired;
		end
	end
	// open-drain style: driven low when expired or supply low
	assign watchdog_expired_n_o = 1'b0;
	assign watchdog_expired_n_oe_n_o = !(wd_expired || !supply_good_i);
	// ------------------------------------------------------------
	// reset pulse width monitor
	// ------------------------------------------------------------
	localparam int unsigned MIN_PULSE_TICKS =
		RESET_TICKS * srw_pkg::RESET_MIN_TICKS / srw_pkg::RESET_TICKS;
	logic [srw_pkg::CNT_W-1:0] pulse_ticks;
	logic [srw_pkg::CNT_W-1:0] next_pulse_ticks;
	// saturates so a long hold cannot wrap back below the minimum
	always_comb begin
		next_pulse_ticks = pulse_ticks;
		if (!reset_o)
			next_pulse_ticks = '0;
		else if (tick && pulse_ticks != '1)
			next_pulse_ticks = pulse_ticks + 16'h0001;
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			pulse_ticks <= '0;
		else
			pulse_ticks <= next_pulse_ticks;
	end
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_supply_low_reset: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i) !supply_good_i |-> reset_o)
		else $error("reset not asserted with supply low");
	chk_reset_complement: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i) reset_o != reset_n_o)
		else $error("reset outputs not complementary");
	chk_supply_low_wdo: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		!supply_good_i |-> !watchdog_expired_n_oe_n_o)
		else $error("expiry not forced low with supply low");
	chk_release_held: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		$fell(hold_cond) |=> reset_o [*8])
		else $error("reset released too soon after supply good");
	chk_run_hold: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		(state == srw_pkg::SRW_RUN) && hold_cond
		|=> state == srw_pkg::SRW_HOLD)
		else $error("hold not entered on supply loss");
	chk_brownout_restart: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		(state == srw_pkg::SRW_STRETCH) && hold_cond |=> rst_cnt == '0)
		else $error("pulse timing not restarted");
	chk_min_pulse: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		$fell(rst_active) |-> rst_cnt == srw_pkg::CNT_W'(RESET_TICKS - 1))
		else $error("reset pulse shorter than full count");
	chk_manual_reset: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		!manual_reset_n_i |=> rst_active)
		else $error("manual reset did not assert reset");
	chk_wd_cleared: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		wd_clear |=> wd_cnt == '0 && !wd_expired)
		else $error("watchdog not cleared");
	chk_wd_sticky: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		wd_expired && !wd_clear |=> wd_expired)
		else $error("expiry released without clear");
	chk_wd_expire: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		$rose(wd_expired)
		|-> $past(wd_cnt) == srw_pkg::CNT_W'(WDOG_TICKS - 1))
		else $error("watchdog expired at wrong count");
	chk_pulse_width: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		$fell(reset_o) |-> pulse_ticks >= srw_pkg::CNT_W'(MIN_PULSE_TICKS))
		else $error("reset pulse shorter than minimum width");
	chk_kick_edge_clear: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		(watchdog_kick_in_i != kick_prev) |=> wd_cnt == '0)
		else $error("kick edge did not clear watchdog");
	chk_wd_restart: assert property (@(posedge mclk_i)
		disable iff (!reset_n_i)
		$fell(wd_clear) |-> wd_cnt == '0 && !wd_expired)
		else $error("watchdog did not restart from zero");
endmodule // srw_supervisor

/* File: verilog/srw_pkg.sv */
// constants shared by the supply reset and watchdog supervisor
package srw_pkg;
	// ------------------------------------------------------------
	// clock and time base
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
	// ------------------------------------------------------------
	// timing, in milliseconds, and derived tick counts
	// ------------------------------------------------------------
	localparam int unsigned RESET_PULSE_MS = 200;
	localparam int unsigned RESET_MIN_MS = 140;
	localparam int unsigned WDOG_TIMEOUT_MS = 1600;
	localparam int unsigned RESET_TICKS = RESET_PULSE_MS * TICK_HZ / 1000;
	localparam int unsigned RESET_MIN_TICKS = RESET_MIN_MS * TICK_HZ / 1000;
	localparam int unsigned WDOG_TICKS = WDOG_TIMEOUT_MS * TICK_HZ / 1000;
	localparam int unsigned CNT_W = 16;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic RESET_ACTIVE_RST = 1'b1;
	localparam logic WDOG_EXPIRED_RST = 1'b0;
	typedef enum logic [1:0] {
		SRW_HOLD,
		SRW_STRETCH,
		SRW_RUN
	} srw_state_type;
endpackage

/* File: verilog/srw_tick_if.sv */
// interface carrying the millisecond tick between supervisor modules
interface srw_tick_if;
	logic tick;
	modport source (output tick);
	modport sink (input tick);
endinterface

/* File: verilog/srw_tick_gen.sv */
// divider producing a one-cycle tick enable
module srw_tick_gen #(
	parameter int unsigned DIV = srw_pkg::TICK_DIV
) (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	srw_tick_if.source tick_o
);
	logic [31:0] count;
	logic [31:0] next_count;
	always_comb begin
		if (count == DIV - 1)
			next_count = '0;
		else
			next_count = count + 32'h00000001;
	end
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			count <= '0;
		else
			count <= next_count;
	end
	assign tick_o.tick = (count == DIV - 1);
endmodule // srw_tick_gen

/* File: tb/srw_cpu_model.sv */
// processor model that kicks the watchdog and can float the kick line
module srw_cpu_model (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic kick_en_i,
	input wire logic float_i,
	input wire logic [15:0] period_i,
	output logic kick_o,
	output logic undriven_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt = 16'h0000;
	initial kick_o = 1'b0;
	initial undriven_o = 1'b0;
	always @(posedge mclk_i) begin
		undriven_o <= float_i;
		if (float_i) begin
			// a floating line wanders every cycle
			kick_o <= ~kick_o;
		end else if (kick_en_i && rst_n_i && cnt >= period_i) begin
			kick_o <= ~kick_o;
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
endmodule // srw_cpu_model

/* File: tb/srw_supervisor_tb_top.sv */
// self-checking bench for the supply reset and watchdog supervisor
module srw_supervisor_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TDIV = 10;
	localparam int RTICKS = 20;
	localparam int WTICKS = 40;
	localparam int SL = TDIV;
	logic mclk = 1'b0, reset_n = 1'b0, supply = 1'b0, man_n = 1'b1;
	logic kick_en = 1'b0, float_en = 1'b0;
	logic [15:0] period = 16'h0014;
	logic kick, undriven, rst, rst_n, wd_out, wd_oe_n, wd_pin;
	logic [31:0] seed = 32'h11E4;
	int bad_count = 0;
	int n_compared = 0;
	// pull-up on the open-drain expiry pin
	assign wd_pin = wd_oe_n ? 1'b1 : wd_out;
	initial forever #5 mclk = ~mclk;
	srw_supervisor #(.TICK_DIV(TDIV), .RESET_TICKS(RTICKS),
		.WDOG_TICKS(WTICKS)) uut (
		.mclk_i(mclk), .reset_n_i(reset_n), .supply_good_i(supply),
		.manual_reset_n_i(man_n), .watchdog_kick_in_i(kick),
		.watchdog_kick_undriven_i(undriven), .reset_o(rst),
		.reset_n_o(rst_n), .watchdog_expired_n_o(wd_out),
		.watchdog_expired_n_oe_n_o(wd_oe_n));
	srw_cpu_model cpu (.mclk_i(mclk), .rst_n_i(rst_n), .kick_en_i(kick_en),
		.float_i(float_en), .period_i(period), .kick_o(kick),
		.undriven_o(undriven));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic int rnd(input int lo, input int span);
		seed = xorshift(seed);
		return lo + int'(seed % span);
	endfunction
	// clocks spanned by a number of time-base ticks
	function automatic int to_clk(input int ticks);
		return ticks * TDIV;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string what, input logic e, input logic g);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, e, g);
		end
	endtask
	task automatic pulse_end(input string what);
		cyc(to_clk(RTICKS) - 2 * SL);
		chk(what, 1'b1, rst);
		cyc(4 * SL);
		chk(what, 1'b0, rst);
		chk("reset_n_o", 1'b1, rst_n);
	endtask
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		cyc(15);
		@(posedge mclk) reset_n <= 1'b1;
		cyc(20);
		chk("reset_o", 1'b1, rst);
		chk("reset_n_o", 1'b0, rst_n);
		chk("expiry pin", 1'b0, wd_pin);
		@(posedge mclk) supply <= 1'b1;
		cyc(1);
		chk("expiry pin", 1'b1, wd_pin);
		pulse_end("power-up reset");
		@(posedge mclk) supply <= 1'b0;
		#1 chk("reset_o", 1'b1, rst);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk) supply <= 1'b1;
			cyc(rnd(20, 130));
			@(posedge mclk) supply <= 1'b0;
			cyc(rnd(1, 8));
		end
		@(posedge mclk) supply <= 1'b1;
		pulse_end("brownout reset");
		@(posedge mclk) man_n <= 1'b0;
		cyc(1);
		chk("reset_o", 1'b1, rst);
		for (int i = 0; i < 6; i++) begin
			cyc(rnd(1, 20));
			@(posedge mclk) man_n <= ~man_n;
		end
		@(posedge mclk) man_n <= 1'b1;
		pulse_end("manual reset");
		period <= 16'(rnd(20, 280));
		kick_en <= 1'b1;
		cyc(1200);
		chk("expiry pin", 1'b1, wd_pin);
		@(kick);
		@(posedge mclk) kick_en <= 1'b0;
		cyc(to_clk(WTICKS) - 2 * SL);
		chk("expiry pin", 1'b1, wd_pin);
		cyc(4 * SL);
		chk("expiry pin", 1'b0, wd_pin);
		cyc(100);
		chk("expiry pin", 1'b0, wd_pin);
		@(posedge mclk) kick_en <= 1'b1;
		@(posedge mclk) kick_en <= 1'b0;
		cyc(3);
		chk("expiry pin", 1'b1, wd_pin);
		cyc(to_clk(WTICKS) - 2 * SL);
		chk("expiry pin", 1'b1, wd_pin);
		cyc(4 * SL);
		chk("expiry pin", 1'b0, wd_pin);
		@(posedge mclk) float_en <= 1'b1;
		cyc(3);
		chk("expiry pin", 1'b1, wd_pin);
		cyc(to_clk(WTICKS) + 100);
		chk("expiry pin", 1'b1, wd_pin);
		tally_and_finish();
	end
endmodule // srw_supervisor_tb_top
